/* File: uvf_fault_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - compare output, mask during ramp/disabled/pre-good
// - threshold is 16-bit, LSB two^-13 volts
// - startup threshold is 0.85 times strap setpoint
// - response byte resets to 80h
// - action codes 10/11 disable then retry
// - fault drives alert low, sticky status bit
// - retry 000 stays off until restart
// - retry 111 restarts until commanded off
// - retry delay (code+1) times 35 ms
// - delay runs attempt start to next start
// - both settings paged, read/write, protected
module uvf_fault_ctrl
   import uvf_pkg::*;
#(
   parameter int UNIT_CYC = RETRY_UNIT_CYC
) (
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   input  wire logic [15:0]       setpoint_strap_i,
   input  wire logic [PAGE_W-1:0] page_i,
   input  wire logic [7:0]        cmd_code_i,
   input  wire logic              wr_en_i,
   input  wire logic [15:0]       wr_data_i,
   input  wire logic              write_protect_i,
   input  wire logic              clear_faults_i,
   input  wire logic [NUM_RAILS-1:0]        rail_on_i,
   input  wire logic [NUM_RAILS-1:0][15:0]  vout_i,
   input  wire logic [NUM_RAILS-1:0]        ramp_done_i,
   input  wire logic [NUM_RAILS-1:0]        output_good_flag_i,
   output logic      [15:0]       rd_data_o,
   output logic      [NUM_RAILS-1:0]        rail_enable_o,
   output logic      [NUM_RAILS-1:0]        uv_fault_status_o,
   output logic                   alert_out_n_o
);
   logic [15:0]          uv_default;
   logic [NUM_RAILS-1:0] tmr_start;
   logic [NUM_RAILS-1:0] tmr_done;
   logic [NUM_RAILS-1:0] uv_event;

   uvf_threshold_init u_init (
      .setpoint_strap_i (setpoint_strap_i),
      .uv_default_o     (uv_default)
   );

   typedef struct packed {
      logic                           loaded;
      logic [NUM_RAILS-1:0][15:0]     limit;
      logic [NUM_RAILS-1:0][7:0]      resp;
      uvf_state_t [NUM_RAILS-1:0]     state;
      logic [NUM_RAILS-1:0]           status;
      logic [NUM_RAILS-1:0]           enable;
      logic [15:0]                    rd_data;
      logic                           alert_n;
   } uvf_ctrl_t;
   uvf_ctrl_t st, next_st;

   genvar g;
   generate
      for (g = 0; g < NUM_RAILS; g++) begin : g_rail
         // only armed once the rail is up and good
         assign uv_event[g] = (st.state[g] == UVF_ON) && rail_on_i[g] && ramp_done_i[g]
                              && output_good_flag_i[g]
                              && (vout_i[g] < st.limit[g]);
         // every attempt start restarts the delay
         assign tmr_start[g] = (st.state[g] != UVF_RAMP) && (next_st.state[g] == UVF_RAMP);
         uvf_retry_timer #(
            .UNIT_CYC (UNIT_CYC)
         ) u_tmr (
            .clk_sys_i    (clk_sys_i),
            .resetn_i     (resetn_i),
            .start_i      (tmr_start[g]),
            .delay_code_i (st.resp[g][DELAY_HI:DELAY_LO]),
            .done_o       (tmr_done[g])
         );

         // checks per rail
         chk_resp_reset: assert property (
            @(posedge clk_sys_i)
            $rose(resetn_i)
            |-> st.resp[g] == RESP_RESET
         )
         else $error("response not at reset value");

         chk_default_load: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            !st.loaded
            |=> st.limit[g] == $past(uv_default) || $past(wr_en_i)
         )
         else $error("threshold default wrong");

         chk_alert_follows: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            uv_event[g] && st.resp[g][ACT_HI]
            |=> !alert_out_n_o && uv_fault_status_o[g]
         )
         else $error("alert not raised on fault");

         chk_status_sticky: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            uv_fault_status_o[g] && !clear_faults_i
            |=> uv_fault_status_o[g]
         )
         else $error("status cleared without command");

         chk_clear_status: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            clear_faults_i && !uv_event[g]
            |=> !uv_fault_status_o[g]
         )
         else $error("status not cleared by command");

         chk_mask_ramp: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            !uv_fault_status_o[g] && (st.state[g] != UVF_ON || !rail_on_i[g]
               || !ramp_done_i[g] || !output_good_flag_i[g])
            |=> !uv_fault_status_o[g]
         )
         else $error("fault not masked");

         chk_good_arm: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            st.state[g] == UVF_RAMP && rail_on_i[g]
               && ramp_done_i[g] && output_good_flag_i[g]
            |=> st.state[g] == UVF_ON
         )
         else $error("check not armed at good");

         chk_disable_fault: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            uv_event[g] && st.resp[g][ACT_HI]
            |=> !rail_enable_o[g]
         )
         else $error("output not disabled");

         chk_unused_action: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            uv_event[g] && !st.resp[g][ACT_HI] && !uv_fault_status_o[g]
            |=> !uv_fault_status_o[g]
         )
         else $error("unused action raised fault");

         chk_noretry_off: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            uv_event[g] && st.resp[g][RETRY_HI:RETRY_LO] == RETRY_NONE && st.resp[g][ACT_HI]
            |=> st.state[g] == UVF_OFF ##1 !rail_enable_o[g]
         )
         else $error("no-retry not off");

         chk_off_hold: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            st.state[g] == UVF_OFF && uv_fault_status_o[g]
            |=> !rail_enable_o[g]
         )
         else $error("faulted rail restarted");

         chk_retry_wait: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            uv_event[g] && st.resp[g][RETRY_HI:RETRY_LO] == RETRY_ALWAYS
               && st.resp[g][ACT_HI] && rail_on_i[g]
            |=> st.state[g] == UVF_WAIT
         )
         else $error("retry not entered");

         chk_wait_off: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            st.state[g] == UVF_WAIT && !rail_on_i[g]
            |=> st.state[g] == UVF_OFF && !rail_enable_o[g]
         )
         else $error("retry not ended by off");

         chk_wait_restart: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            st.state[g] == UVF_WAIT && tmr_done[g] && rail_on_i[g]
            |=> st.state[g] == UVF_RAMP && rail_enable_o[g]
         )
         else $error("retry attempt not started");

         chk_wp_hold: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            st.loaded && write_protect_i
            |=> $stable(st.limit[g]) && $stable(st.resp[g])
         )
         else $error("protected write took effect");

         chk_rd_limit: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            cmd_code_i == CMD_UV_LIMIT && page_i == PAGE_W'(g)
            |=> rd_data_o == $past(st.limit[g])
         )
         else $error("limit readback wrong");

         // scenario covers
         cov_fault: cover property (
            @(posedge clk_sys_i) uv_event[g]);
         cov_retry: cover property (
            @(posedge clk_sys_i) st.state[g] == UVF_WAIT ##1 st.state[g] == UVF_RAMP);
         cov_clear: cover property (
            @(posedge clk_sys_i) uv_fault_status_o[g] ##1 !uv_fault_status_o[g]);
         cov_unused: cover property (
            @(posedge clk_sys_i) uv_event[g] && !st.resp[g][ACT_HI]);
         cov_wp_write: cover property (
            @(posedge clk_sys_i) wr_en_i && write_protect_i);
      end
   endgenerate

   always_comb begin
      next_st = st;
      if (!st.loaded) begin
         next_st.loaded = 1'b1;
         for (int i = 0; i < NUM_RAILS; i++) begin
            next_st.limit[i] = uv_default;
         end
      end
      if (wr_en_i && !write_protect_i) begin
         if (cmd_code_i == CMD_UV_LIMIT) begin
            next_st.limit[page_i] = wr_data_i;
         end else if (cmd_code_i == CMD_UV_RESP) begin
            next_st.resp[page_i] = wr_data_i[7:0];
         end
      end
      unique case (cmd_code_i)
         CMD_UV_LIMIT: next_st.rd_data = st.limit[page_i];
         CMD_UV_RESP:  next_st.rd_data = {8'h00, st.resp[page_i]};
         default:      next_st.rd_data = 16'h0000;
      endcase
      for (int i = 0; i < NUM_RAILS; i++) begin
         if (clear_faults_i) begin
            next_st.status[i] = 1'b0;
         end
         if (uv_event[i] && st.resp[i][ACT_HI]) begin
            next_st.status[i] = 1'b1;
         end
         unique case (st.state[i])
            UVF_OFF: begin
               next_st.enable[i] = 1'b0;
               if (rail_on_i[i] && !st.status[i]) begin
                  next_st.state[i]  = UVF_RAMP;
                  next_st.enable[i] = 1'b1;
               end
            end
            UVF_RAMP: begin
               next_st.enable[i] = 1'b1;
               if (!rail_on_i[i]) begin
                  next_st.state[i]  = UVF_OFF;
                  next_st.enable[i] = 1'b0;
               end else if (ramp_done_i[i] && output_good_flag_i[i]) begin
                  next_st.state[i] = UVF_ON;
               end
            end
            UVF_ON: begin
               if (!rail_on_i[i]) begin
                  next_st.state[i]  = UVF_OFF;
                  next_st.enable[i] = 1'b0;
               end else if (uv_event[i] && st.resp[i][ACT_HI]) begin
                  next_st.enable[i] = 1'b0;
                  if (st.resp[i][RETRY_HI:RETRY_LO] == RETRY_ALWAYS) begin
                     next_st.state[i] = UVF_WAIT;
                  end else begin
                     next_st.state[i] = UVF_OFF;
                  end
               end
            end
            UVF_WAIT: begin
               next_st.enable[i] = 1'b0;
               if (!rail_on_i[i]) begin
                  next_st.state[i] = UVF_OFF;
               end else if (tmr_done[i]) begin
                  next_st.state[i]  = UVF_RAMP;
                  next_st.enable[i] = 1'b1;
               end
            end
            default: begin
               next_st.state[i]  = UVF_OFF;
               next_st.enable[i] = 1'b0;
            end
         endcase
      end
      next_st.alert_n = ~(|next_st.status);
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st         <= '0;
         st.resp    <= {NUM_RAILS{RESP_RESET}};
         for (int i = 0; i < NUM_RAILS; i++) begin
            st.state[i] <= UVF_OFF;
         end
         st.alert_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data_o         = st.rd_data;
   assign rail_enable_o     = st.enable;
   assign uv_fault_status_o = st.status;
   assign alert_out_n_o     = st.alert_n;

endmodule
`default_nettype wire

/* File: uvf_pkg.sv */
package uvf_pkg;
   localparam int          NUM_RAILS     = 2;
   localparam int          PAGE_W        = 1;
   localparam logic [7:0]  CMD_UV_LIMIT  = 8'h44;
   localparam logic [7:0]  CMD_UV_RESP   = 8'h45;
   localparam logic [7:0]  RESP_RESET    = 8'h80;
   localparam int          ACT_HI        = 7;
   localparam int          ACT_LO        = 6;
   localparam int          RETRY_HI      = 5;
   localparam int          RETRY_LO      = 3;
   localparam int          DELAY_HI      = 2;
   localparam int          DELAY_LO      = 0;
   localparam logic [2:0]  RETRY_NONE    = 3'h0;
   localparam logic [2:0]  RETRY_ALWAYS  = 3'h7;
   localparam int          VOUT_FRAC     = 13;
   // 0.85 as 17/20
   localparam logic [4:0]  UV_SCALE_NUM  = 5'h11;
   localparam logic [4:0]  UV_SCALE_DEN  = 5'h14;
   localparam int          CLK_HZ        = 10_000_000;
   localparam int          RETRY_UNIT_MS = 35;
   localparam int          RETRY_UNIT_CYC = CLK_HZ / 1000 * RETRY_UNIT_MS;
   localparam int          TMR_W         = 22;
   typedef enum logic [3:0] {
      UVF_OFF   = 4'b0001,
      UVF_RAMP  = 4'b0010,
      UVF_ON    = 4'b0100,
      UVF_WAIT  = 4'b1000
   } uvf_state_t;
endpackage

/* File: uvf_threshold_init.sv */
`timescale 1ns/1ns
`default_nettype none
module uvf_threshold_init
   import uvf_pkg::*;
(
   input  wire logic [15:0] setpoint_strap_i,
   output logic      [15:0] uv_default_o
);
   logic [20:0] prod;
   always_comb begin
      prod         = 21'(setpoint_strap_i) * 21'(UV_SCALE_NUM);
      uv_default_o = 16'(prod / 21'(UV_SCALE_DEN));
   end
endmodule
`default_nettype wire

/* File: uvf_retry_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module uvf_retry_timer
   import uvf_pkg::*;
#(
   parameter int UNIT_CYC = RETRY_UNIT_CYC
) (
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic       start_i,
   input  wire logic [2:0] delay_code_i,
   output logic            done_o
);
   typedef struct packed {
      logic [TMR_W-1:0] unit_cnt;
      logic [3:0]       units;
      logic             run;
      logic             done;
   } uvf_tmr_t;
   uvf_tmr_t st, next_st;
   always_comb begin
      next_st = st;
      if (start_i) begin
         // done stays up until the next attempt starts
         next_st.run      = 1'b1;
         next_st.done     = 1'b0;
         next_st.unit_cnt = '0;
         next_st.units    = 4'(delay_code_i) + 4'h1;
      end else if (st.run) begin
         if (st.unit_cnt == TMR_W'(UNIT_CYC - 1)) begin
            next_st.unit_cnt = '0;
            next_st.units    = st.units - 4'h1;
            if (st.units == 4'h1) begin
               next_st.run  = 1'b0;
               next_st.done = 1'b1;
            end
         end else begin
            next_st.unit_cnt = st.unit_cnt + TMR_W'(1);
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign done_o = st.done;
endmodule
`default_nettype wire

/* File: uvf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module uvf_host_model
   import uvf_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic [15:0]       rd_data_i,
   output logic      [PAGE_W-1:0] page_o,
   output logic      [7:0]        cmd_code_o,
   output logic                   wr_en_o,
   output logic      [15:0]       wr_data_o
);
   initial begin
      page_o = '0;
      cmd_code_o = 8'h00;
      wr_en_o = 1'b0;
      wr_data_o = 16'h0000;
   end
   task automatic wr(input logic [PAGE_W-1:0] p, input logic [7:0] c, input logic [15:0] v);
      @(posedge clk_sys_i);
      #10;
      page_o = p;
      cmd_code_o = c;
      wr_data_o = v;
      wr_en_o = 1'b1;
      @(posedge clk_sys_i);
      #10;
      wr_en_o = 1'b0;
      // released data shows no stale value
      wr_data_o = ~v;
   endtask
   task automatic rd(input logic [PAGE_W-1:0] p, input logic [7:0] c, output logic [15:0] q);
      @(posedge clk_sys_i);
      #10;
      page_o = p;
      cmd_code_o = c;
      @(posedge clk_sys_i);
      #10;
      q = rd_data_i;
   endtask
endmodule
`default_nettype wire

/* File: uvf_fault_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module uvf_fault_ctrl_tb
   import uvf_pkg::*;
;
   localparam int          UNIT  = 10;
   localparam logic [15:0] STRAP = 16'h2000;
   // 0.85 of the strap, truncated
   localparam logic [15:0] LIM   = 16'((32'(STRAP) * 17) / 20);
   logic                       clk_sys_i = 1'b0;
   logic                       resetn_i  = 1'b0;
   logic                       wp        = 1'b0;
   logic                       clr       = 1'b0;
   logic [NUM_RAILS-1:0]       on        = '0;
   logic [NUM_RAILS-1:0]       ramp      = '0;
   logic [NUM_RAILS-1:0]       good      = '0;
   logic [NUM_RAILS-1:0][15:0] vout      = '0;
   logic [PAGE_W-1:0]          page;
   logic [7:0]                 cmd;
   logic                       wr_en;
   logic [15:0]                wr_data, rd_data, d;
   logic [NUM_RAILS-1:0]       rail_en, status;
   logic                       alert_n;
   int                         num_errors  = 0;
   int                         check_count = 0;
   int                         n;
   always #50 clk_sys_i = ~clk_sys_i;
   uvf_host_model i_host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data), .page_o(page),
      .cmd_code_o(cmd), .wr_en_o(wr_en), .wr_data_o(wr_data));
   uvf_fault_ctrl #(.UNIT_CYC(UNIT)) i_dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .setpoint_strap_i(STRAP),
      .page_i(page), .cmd_code_i(cmd), .wr_en_i(wr_en), .wr_data_i(wr_data),
      .write_protect_i(wp), .clear_faults_i(clr), .rail_on_i(on), .vout_i(vout),
      .ramp_done_i(ramp), .output_good_flag_i(good), .rd_data_o(rd_data),
      .rail_enable_o(rail_en), .uv_fault_status_o(status), .alert_out_n_o(alert_n));
   task automatic tick(input int k = 1);
      repeat (k) @(posedge clk_sys_i);
      #10;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic bound(input logic ok, input string what);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("BAD %0t timeout %s", $time, what);
         final_report();
      end
   endtask
   task automatic clear();
      clr = 1'b1;
      tick();
      clr = 1'b0;
      tick(2);
   endtask
   task automatic t_reset();
      for (int p = 0; p < NUM_RAILS; p++) begin
         i_host.rd(PAGE_W'(p), CMD_UV_LIMIT, d);
         chk(d, LIM, "default limit");
         i_host.rd(PAGE_W'(p), CMD_UV_RESP, d);
         chk(d, {8'h00, RESP_RESET}, "default action");
      end
      i_host.rd('0, 8'h46, d);
      chk(d, 16'h0000, "unmapped read");
      $display("test reset done");
   endtask
   task automatic t_rw();
      i_host.wr(1'b1, CMD_UV_LIMIT, 16'h1800);
      i_host.wr(1'b0, CMD_UV_RESP, 16'hFF3A);
      i_host.rd(1'b1, CMD_UV_LIMIT, d);
      chk(d, 16'h1800, "page 1 limit");
      i_host.rd(1'b0, CMD_UV_LIMIT, d);
      chk(d, LIM, "page 0 limit");
      i_host.rd(1'b0, CMD_UV_RESP, d);
      chk(d, 16'h003A, "page 0 action");
      wp = 1'b1;
      i_host.wr(1'b1, CMD_UV_LIMIT, 16'h0100);
      i_host.rd(1'b1, CMD_UV_LIMIT, d);
      chk(d, 16'h1800, "protected write");
      wp = 1'b0;
      i_host.wr(1'b0, CMD_UV_RESP, 16'h0080);
      $display("test paged access done");
   endtask
   task automatic t_no_retry();
      vout[0] = 16'h0100;
      on[0] = 1'b1;
      tick(5);
      chk(16'({alert_n, status[0], rail_en[0]}), 16'h0005, "ramp masked");
      ramp[0] = 1'b1;
      tick(5);
      chk(16'({alert_n, status[0], rail_en[0]}), 16'h0005, "pre-good masked");
      good[0] = 1'b1;
      for (n = 0; n < 5 && status[0] !== 1'b1; n++) tick();
      bound(status[0], "uv fault");
      tick();
      chk(16'({alert_n, status[0], rail_en[0]}), 16'h0002, "fault shutdown");
      tick(50);
      chk(16'(rail_en[0]), 16'h0000, "stays off");
      on[0] = 1'b0;
      tick(3);
      chk(16'(status[0]), 16'h0001, "sticky status");
      clear();
      chk(16'({alert_n, status[0]}), 16'h0002, "cleared");
      tick(5);
      chk(16'({alert_n, status[0]}), 16'h0002, "disabled masked");
      ramp[0] = 1'b0;
      good[0] = 1'b0;
      $display("test no retry done");
   endtask
   task automatic t_retry();
      i_host.wr(1'b1, CMD_UV_RESP, 16'h00FA);
      vout[1] = 16'h0100;
      on[1] = 1'b1;
      tick();
      // n counts edges since the attempt started
      for (int k = 0; k < 2; k++) begin
         chk(16'(rail_en[1]), 16'h0001, "soft start rerun");
         ramp[1] = 1'b1;
         good[1] = 1'b1;
         for (n = 0; n < 5 && rail_en[1] !== 1'b0; n++) tick();
         bound(!rail_en[1], "retry shutdown");
         ramp[1] = 1'b0;
         good[1] = 1'b0;
         tick();
         chk(16'({alert_n, status[1]}), 16'h0001, "retry fault");
         for (n = n + 1; n < 40 && rail_en[1] !== 1'b1; n++) tick();
         bound(rail_en[1], "retry restart");
         chk(16'(n >= 3 * UNIT && n <= 3 * UNIT + 2), 16'h0001, "retry delay");
      end
      ramp[1] = 1'b1;
      good[1] = 1'b1;
      tick(3);
      on[1] = 1'b0;
      tick(3 * UNIT + 10);
      chk(16'(rail_en[1]), 16'h0000, "off ends retry");
      ramp[1] = 1'b0;
      good[1] = 1'b0;
      clear();
      $display("test retry done");
   endtask
   task automatic t_unused();
      for (int k = 0; k < 2; k++) begin
         i_host.wr(1'b0, CMD_UV_RESP, (k == 0) ? 16'h0038 : 16'h0078);
         on[0] = 1'b1;
         ramp[0] = 1'b1;
         good[0] = 1'b1;
         tick(10);
         chk(16'({alert_n, status[0], rail_en[0]}), 16'h0005, "unused action");
         on[0] = 1'b0;
         tick(3);
      end
      $display("test unused action done");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_i);
      #10;
      resetn_i = 1'b1;
      tick(2);
      t_reset();
      t_rw();
      t_no_retry();
      t_retry();
      t_unused();
      final_report();
   end
endmodule
`default_nettype wire
